// [rtl/aotf_consts.vh]
// constants of the output test and format control block
`ifndef AOTF_CONSTS_VH
`define AOTF_CONSTS_VH

// register addresses (13-bit serial port address space)
`define AOTF_A_DEVIDX    13'h0005
`define AOTF_A_ENH       13'h000C
`define AOTF_A_TEST      13'h000D
`define AOTF_A_TRIM      13'h0010
`define AOTF_A_OMODE     13'h0014
`define AOTF_A_ODRV      13'h0015
`define AOTF_A_UP1L      13'h0019
`define AOTF_A_UP1H      13'h001A
`define AOTF_A_UP2L      13'h001B
`define AOTF_A_UP2H      13'h001C

// reset values
`define AOTF_R_DEVIDX    6'h3F
`define AOTF_R_TEST      8'h00
`define AOTF_R_TRIM      8'h00
`define AOTF_R_OMODE     8'h01
`define AOTF_R_ENH       8'h00
`define AOTF_R_ODRV      8'h00
`define AOTF_R_UP        16'h0000

// writable bit masks of the byte-wide registers
`define AOTF_M_ENH       8'h04
`define AOTF_M_TEST      8'hCF
`define AOTF_M_ODRV      8'h31

// field positions
`define AOTF_B_PNLRST    5
`define AOTF_B_PNSRST    4
`define AOTF_B_INV       2
`define AOTF_B_FMT       0
`define AOTF_B_LVDS      6

// pattern select codes
`define AOTF_P_OFF       4'h0
`define AOTF_P_MID       4'h1
`define AOTF_P_PFS       4'h2
`define AOTF_P_NFS       4'h3
`define AOTF_P_CHK       4'h4
`define AOTF_P_PNL       4'h5
`define AOTF_P_PNS       4'h6
`define AOTF_P_WTGL      4'h7
`define AOTF_P_USER      4'h8
`define AOTF_P_BALT      4'h9
`define AOTF_P_SYNC      4'hA
`define AOTF_P_BTGL      4'hB

// user pattern modes
`define AOTF_U_SINGLE    2'h0
`define AOTF_U_ALT       2'h1
`define AOTF_U_SONCE     2'h2
`define AOTF_U_AONCE     2'h3

// pattern words (14-bit, offset binary)
`define AOTF_W_MID       14'h2000
`define AOTF_W_PFS       14'h3FFF
`define AOTF_W_NFS       14'h0000
`define AOTF_W_ALTA      14'h2AAA
`define AOTF_W_ALTB      14'h1555
`define AOTF_W_SYNC      14'h3F80
`define AOTF_W_MAX       14'h3FFF

// pseudorandom generator seeds
`define AOTF_PNL_SEED    23'h7FFFFF
`define AOTF_PNS_SEED    9'h1FF

// serial port frame: 16 instruction bits then 8 data bits
`define AOTF_SPI_INSTR   5'h10
`define AOTF_SPI_LAST    5'h17
`define AOTF_SPI_END     5'h18

`endif

// [rtl/aotf_top.v]
// output test pattern and format control with serial register port
`timescale 1ns/1ps
`include "aotf_consts.vh"

// ------------------------------------------------------------
// fifo between formatter and output stream
// ------------------------------------------------------------
module aotf_fifo #(
   parameter W  = 112,
   parameter AW = 4
) (
   input  wire         CLK,
   input  wire         SRST,
   input  wire         IN_VALID,
   output wire         IN_READY,
   input  wire [W-1:0] IN_DATA,
   output wire         OUT_VALID,
   input  wire         OUT_READY,
   output wire [W-1:0] OUT_DATA
);
   reg [W-1:0] mem [0:(1<<AW)-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0]   cnt_q;
   wire push = IN_VALID & IN_READY;
   wire pop  = OUT_VALID & OUT_READY;

   assign IN_READY  = (cnt_q != (1 << AW));
   assign OUT_VALID = (cnt_q != 0);
   assign OUT_DATA  = mem[rp_q];      // words sit in flops

   // pointers and fill count
   always @(posedge CLK) begin
      if (SRST) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
         if (push & ~pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   // storage has no reset; only words behind wp_q are ever read
   always @(posedge CLK) begin
      if (push)
         mem[wp_q] <= IN_DATA;
   end
endmodule

// ------------------------------------------------------------
// top: register port, pattern generators, per-channel formatter
// ------------------------------------------------------------
module aotf_top #(
   parameter NCH = 8,
   parameter DW  = 14,
   parameter FAW = 4
) (
   input  wire            CLK,
   input  wire            SRST,
   input  wire            SCLK,
   input  wire            CSB,
   input  wire            SDIO_IN,
   output wire            SDIO_OUT,
   output wire            SDIO_OE,
   input  wire            IN_VALID,
   output wire            IN_READY,
   input  wire [NCH*DW-1:0] IN_DATA,
   output wire            OUT_VALID,
   input  wire            OUT_READY,
   output wire [NCH*DW-1:0] OUT_DATA
);
   // pattern word for a test code; user word and alternation given
   function [DW-1:0] pat_word;
      input [3:0]    code;
      input          tgl;
      input [DW-1:0] pnl;
      input [DW-1:0] pns;
      input [DW-1:0] usr;
      begin
         case (code)
            `AOTF_P_MID:  pat_word = `AOTF_W_MID;
            `AOTF_P_PFS:  pat_word = `AOTF_W_PFS;
            `AOTF_P_NFS:  pat_word = `AOTF_W_NFS;
            `AOTF_P_CHK:  pat_word = tgl ? `AOTF_W_ALTB : `AOTF_W_ALTA;
            `AOTF_P_PNL:  pat_word = pnl;
            `AOTF_P_PNS:  pat_word = pns;
            `AOTF_P_WTGL: pat_word = tgl ? `AOTF_W_NFS : `AOTF_W_PFS;
            `AOTF_P_USER: pat_word = usr;
            `AOTF_P_BALT: pat_word = `AOTF_W_ALTA;
            `AOTF_P_SYNC: pat_word = `AOTF_W_SYNC;
            `AOTF_P_BTGL: pat_word = tgl ? `AOTF_W_ALTB : `AOTF_W_ALTA;
            default:      pat_word = `AOTF_W_NFS;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // serial register port
   // ------------------------------------------------------------
   reg        sclk_q;
   reg [4:0]  bit_q;
   reg [15:0] ins_q;
   reg [6:0]  wsh_q;
   reg [7:0]  rsh_q;
   reg        oe_q;
   wire       rise = SCLK & ~sclk_q & ~CSB;
   wire       fall = ~SCLK & sclk_q & ~CSB;
   wire [12:0] addr = ins_q[12:0];
   wire       wr = rise & (bit_q == `AOTF_SPI_LAST) & ~ins_q[15];
   wire [7:0] wdat = {wsh_q, SDIO_IN};
   reg  [7:0] rd_val;

   assign SDIO_OUT = rsh_q[7];
   assign SDIO_OE  = oe_q;

   // frame counter: one byte per frame, extra clocks are ignored
   always @(posedge CLK) begin
      if (SRST) begin
         sclk_q <= 1'b0;
         bit_q  <= 5'h00;
         ins_q  <= 16'h0000;
         wsh_q  <= 7'h00;
         rsh_q  <= 8'h00;
         oe_q   <= 1'b0;
      end else begin
         sclk_q <= SCLK;
         if (CSB) begin
            bit_q <= 5'h00;
            oe_q  <= 1'b0;
         end else begin
            if (rise && bit_q != `AOTF_SPI_END) begin
               bit_q <= bit_q + 5'h01;
               if (bit_q < `AOTF_SPI_INSTR)
                  ins_q <= {ins_q[14:0], SDIO_IN};
               else
                  wsh_q <= {wsh_q[5:0], SDIO_IN};
            end
            // read data leaves on falling edges after the instruction
            if (fall) begin
               if (bit_q == `AOTF_SPI_INSTR && ins_q[15]) begin
                  rsh_q <= rd_val;
                  oe_q  <= 1'b1;
               end else if (bit_q == `AOTF_SPI_END) begin
                  oe_q  <= 1'b0;
               end else if (oe_q) begin
                  rsh_q <= {rsh_q[6:0], 1'b0};
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // global registers
   // ------------------------------------------------------------
   reg [5:0]  devidx_q;
   reg        fmt_q;
   reg        lvds_q;
   reg        pnl_rst_q;
   reg        pns_rst_q;
   reg [15:0] up1_q;
   reg [15:0] up2_q;
   // reset image of the output mode register, so one field can be picked
   localparam [7:0] omode_rst = `AOTF_R_OMODE;

   always @(posedge CLK) begin
      if (SRST) begin
         devidx_q  <= `AOTF_R_DEVIDX;
         fmt_q     <= omode_rst[`AOTF_B_FMT];
         lvds_q    <= 1'b0;
         pnl_rst_q <= 1'b0;
         pns_rst_q <= 1'b0;
         up1_q     <= `AOTF_R_UP;
         up2_q     <= `AOTF_R_UP;
      end else if (wr) begin
         case (addr)
            `AOTF_A_DEVIDX: devidx_q <= wdat[5:0];
            `AOTF_A_TEST: begin
               // generator holds ignore the channel selection
               pnl_rst_q <= wdat[`AOTF_B_PNLRST];
               pns_rst_q <= wdat[`AOTF_B_PNSRST];
            end
            `AOTF_A_OMODE: begin
               fmt_q  <= wdat[`AOTF_B_FMT];
               lvds_q <= wdat[`AOTF_B_LVDS];
            end
            `AOTF_A_UP1L: up1_q[7:0]  <= wdat;
            `AOTF_A_UP1H: up1_q[15:8] <= wdat;
            `AOTF_A_UP2L: up2_q[7:0]  <= wdat;
            `AOTF_A_UP2H: up2_q[15:8] <= wdat;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // shared pattern sources
   // ------------------------------------------------------------
   reg  [22:0] pnl_q;
   reg  [8:0]  pns_q;
   reg         tgl_q;
   wire        fifo_rdy;
   wire        push = IN_VALID & fifo_rdy;
   wire [NCH*DW-1:0] fmt_data;

   assign IN_READY = fifo_rdy;

   // generators step once per accepted sample set, held while reset bit set
   always @(posedge CLK) begin
      if (SRST) begin
         pnl_q <= `AOTF_PNL_SEED;
         pns_q <= `AOTF_PNS_SEED;
         tgl_q <= 1'b0;
      end else begin
         if (pnl_rst_q)
            pnl_q <= `AOTF_PNL_SEED;
         else if (push)
            pnl_q <= {pnl_q[21:0], pnl_q[22] ^ pnl_q[17]};
         if (pns_rst_q)
            pns_q <= `AOTF_PNS_SEED;
         else if (push)
            pns_q <= {pns_q[7:0], pns_q[8] ^ pns_q[4]};
         if (push)
            tgl_q <= ~tgl_q;
      end
   end

   // ------------------------------------------------------------
   // per-channel registers and formatter
   // ------------------------------------------------------------
   wire [NCH*8-1:0] tm_f;
   wire [NCH*8-1:0] trim_f;
   wire [NCH*8-1:0] enh_f;
   wire [NCH*8-1:0] drv_f;
   wire [NCH-1:0]   inv_f;

   genvar i;
   generate
      for (i = 0; i < NCH; i = i + 1) begin : g_ch
         reg  [7:0]    tm_q;
         reg  [7:0]    trim_q;
         reg  [7:0]    enh_q;
         reg  [7:0]    drv_q;
         reg           inv_q;
         reg  [1:0]    ucnt_q;
         reg  [DW-1:0] usr;
         reg  [DW-1:0] word;
         reg  [15:0]   sum;
         wire          sel = devidx_q[i/2];
         wire          cw = wr & sel;
         wire [DW-1:0] smp = IN_DATA[i*DW +: DW];

         assign tm_f[i*8 +: 8]   = tm_q;
         assign trim_f[i*8 +: 8] = trim_q;
         assign enh_f[i*8 +: 8]  = enh_q;
         assign drv_f[i*8 +: 8]  = drv_q;
         assign inv_f[i]         = inv_q;

         // local registers, written only when this channel is selected
         always @(posedge CLK) begin
            if (SRST) begin
               tm_q   <= `AOTF_R_TEST;
               trim_q <= `AOTF_R_TRIM;
               enh_q  <= `AOTF_R_ENH;
               drv_q  <= `AOTF_R_ODRV;
               inv_q  <= 1'b0;
               ucnt_q <= 2'h0;
            end else begin
               if (cw && addr == `AOTF_A_TEST) begin
                  tm_q   <= wdat & `AOTF_M_TEST;
                  ucnt_q <= 2'h0;                             // restart once
               end else if (push && tm_q[3:0] == `AOTF_P_USER) begin
                  if (!tm_q[7])
                     ucnt_q <= {1'b0, ~ucnt_q[0]};
                  else if (ucnt_q != 2'h2)
                     ucnt_q <= ucnt_q + 2'h1;
               end
               if (cw && addr == `AOTF_A_TRIM)
                  trim_q <= wdat;
               if (cw && addr == `AOTF_A_ENH)
                  enh_q <= wdat & `AOTF_M_ENH;
               if (cw && addr == `AOTF_A_ODRV)
                  drv_q <= wdat & `AOTF_M_ODRV;
               if (cw && addr == `AOTF_A_OMODE)
                  inv_q <= wdat[`AOTF_B_INV];
            end
         end

         // user word; once modes fall to zero after the last word
         always @* begin
            case (tm_q[7:6])
               `AOTF_U_SINGLE: usr = up1_q[15:16-DW];
               `AOTF_U_ALT:    usr = ucnt_q[0] ? up2_q[15:16-DW]
                                               : up1_q[15:16-DW];
               `AOTF_U_SONCE:  usr = (ucnt_q == 2'h0) ? up1_q[15:16-DW]
                                                      : {DW{1'b0}};
               `AOTF_U_AONCE:  usr = (ucnt_q == 2'h0) ? up1_q[15:16-DW] :
                                     (ucnt_q == 2'h1) ? up2_q[15:16-DW] :
                                     {DW{1'b0}};
               default:        usr = up1_q[15:16-DW];
            endcase
         end

         // trim with saturation, then coding, then complement
         always @* begin
            sum = {2'b00, smp} + {{8{trim_q[7]}}, trim_q};
            if (sum[15])
               word = {DW{1'b0}};
            else if (sum[14])
               word = `AOTF_W_MAX;
            else
               word = sum[DW-1:0];
            if (fmt_q)
               word[DW-1] = ~word[DW-1];
            if (inv_q)
               word = ~word;
            // test data bypasses trim, coding and inversion
            if (tm_q[3:0] != `AOTF_P_OFF && tm_q[3:0] <= `AOTF_P_BTGL)
               word = pat_word(tm_q[3:0], tgl_q, pnl_q[DW-1:0],
                               {pns_q, pnl_q[DW-10:0]}, usr);
         end

         assign fmt_data[i*DW +: DW] = word;
      end
   endgenerate

   // readback shows the lowest-numbered selected channel
   wire [2:0] rc = devidx_q[0] ? 3'd0 : devidx_q[1] ? 3'd2 :
                   devidx_q[2] ? 3'd4 : devidx_q[3] ? 3'd6 : 3'd0;

   always @* begin
      case (addr)
         `AOTF_A_DEVIDX: rd_val = {2'b00, devidx_q};
         `AOTF_A_ENH:    rd_val = enh_f[rc*8 +: 8];
         `AOTF_A_TEST:   rd_val = tm_f[rc*8 +: 8] |
                                  {2'b00, pnl_rst_q, pns_rst_q, 4'h0};
         `AOTF_A_TRIM:   rd_val = trim_f[rc*8 +: 8];
         `AOTF_A_OMODE:  rd_val = {1'b0, lvds_q, 3'b000, inv_f[rc],
                                   1'b0, fmt_q};
         `AOTF_A_ODRV:   rd_val = drv_f[rc*8 +: 8];
         `AOTF_A_UP1L:   rd_val = up1_q[7:0];
         `AOTF_A_UP1H:   rd_val = up1_q[15:8];
         `AOTF_A_UP2L:   rd_val = up2_q[7:0];
         `AOTF_A_UP2H:   rd_val = up2_q[15:8];
         default:        rd_val = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // output buffer; a stalled consumer back-pressures IN_READY
   // ------------------------------------------------------------
   aotf_fifo #(
      .W  (NCH*DW),
      .AW (FAW)
   ) u_fifo (
      .CLK       (CLK),
      .SRST      (SRST),
      .IN_VALID  (IN_VALID),
      .IN_READY  (fifo_rdy),
      .IN_DATA   (fmt_data),
      .OUT_VALID (OUT_VALID),
      .OUT_READY (OUT_READY),
      .OUT_DATA  (OUT_DATA)
   );
endmodule

// [sim/aotf_host.sv]
// serial port host model that programs the block's registers
`timescale 1ns/1ps
module aotf_host (
   input  wire  clk,
   input  wire  sdio_out,
   input  wire  sdio_oe,
   output logic sclk = 1'b0,
   output logic csb = 1'b1,
   output wire  sdio
);
   logic drv_q = 1'b0;
   // a released line shows the inverse of its last level, never a stale copy
   assign sdio = sdio_oe ? sdio_out : drv_q;
   // one frame: read flag, two zero bits, address, data; sclk idles low
   task automatic xfer(input logic rd, input logic [12:0] a,
                       input logic [7:0] wd, output logic [7:0] rv);
      logic [23:0] f;
      f = {rd, 2'b00, a, wd};
      rv = 8'h00;
      csb <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         @(posedge clk);
         sclk <= 1'b0;
         drv_q <= (rd && i > 15) ? ~f[8] : f[23-i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         rv = {rv[6:0], sdio};   // taken at the end of the high phase
      end
      @(posedge clk);
      sclk <= 1'b0;
      drv_q <= ~f[rd ? 8 : 0];
      repeat (4) @(posedge clk);
      csb <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule

// [sim/aotf_top_asserts.sv]
// port-level assertions for the output test and format block
`timescale 1ns/1ps
module aotf_chk #(
   parameter NCH = 8,
   parameter DW  = 14,
   parameter FAW = 4
) (
   input logic              CLK,
   input logic              SRST,
   input logic              SCLK,
   input logic              CSB,
   input logic              SDIO_OUT,
   input logic              SDIO_OE,
   input logic              IN_VALID,
   input logic              IN_READY,
   input logic              OUT_VALID,
   input logic              OUT_READY,
   input logic [NCH*DW-1:0] OUT_DATA
);
   localparam DEPTH = 1 << FAW;
   logic [FAW:0] cnt_q;
   // occupancy shadow, so fullness is judged without seeing the fifo body
   always @(posedge CLK) begin
      if (SRST) cnt_q <= '0;
      else cnt_q <= cnt_q + (IN_VALID && IN_READY) - (OUT_VALID && OUT_READY);
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence s_push; IN_VALID && IN_READY; endsequence
   sequence s_sclk_hi; SCLK [*2]; endsequence
   property p_rst; $fell(SRST) |-> !OUT_VALID && IN_READY && !SDIO_OE;
   endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_hold; OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA);
   endproperty
   a_hold: assert property (p_hold) else $error("output word moved");
   property p_full; IN_READY == (cnt_q != DEPTH); endproperty
   a_full: assert property (p_full) else $error("ready vs fill level");
   property p_empty; OUT_VALID == (cnt_q != 0); endproperty
   a_empty: assert property (p_empty) else $error("valid vs fill level");
   property p_first; s_push and !OUT_VALID |=> OUT_VALID; endproperty
   a_first: assert property (p_first) else $error("push not shown");
   property p_oe_cs; CSB && $past(CSB) |-> !SDIO_OE; endproperty
   a_oe_cs: assert property (p_oe_cs) else $error("drives when idle");
   property p_oe_rise; $rose(SDIO_OE) |-> !SCLK && !CSB; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("late turn");
   property p_sdo; s_sclk_hi |-> !SDIO_OE || $stable(SDIO_OUT); endproperty
   a_sdo: assert property (p_sdo) else $error("read bit moved");
endmodule
bind aotf_top aotf_chk #(.NCH(NCH), .DW(DW), .FAW(FAW)) u_chk (
   .CLK(CLK), .SRST(SRST), .SCLK(SCLK), .CSB(CSB), .SDIO_OUT(SDIO_OUT),
   .SDIO_OE(SDIO_OE), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
   .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA));

// [sim/tb_aotf_top.sv]
// self-checking bench for the output test and format block
`timescale 1ns/1ps
module tb_aotf_top;
   logic         clk = 1'b0;
   logic         srst = 1'b1;
   logic         in_valid = 1'b0;
   logic         out_ready = 1'b0;
   logic [111:0] in_data = '0;
   wire          sclk, csb, sdio, sdio_out, sdio_oe, in_ready, out_valid;
   wire  [111:0] out_data;
   int           failures = 0;
   int           checks_done = 0;
   int           cyc = 0;
   int           pushes = 0;
   logic [7:0]   trim_e [8] = '{default: 8'h00};
   logic [7:0]   inv_e = 8'h00;
   logic         tc_e = 1'b1;
   logic [111:0] e;
   localparam logic [111:0] S = {14'h1FFF, 14'h0001, 14'h3000, 14'h0ABC,
                                 14'h2345, 14'h1234, 14'h0010, 14'h3FF0};
   localparam logic [12:0] RA [11] = '{13'h05, 13'h0C, 13'h0D, 13'h10,
      13'h14, 13'h15, 13'h19, 13'h1A, 13'h1B, 13'h1C, 13'h30};
   localparam logic [7:0] RV [11] = '{8'h3F, 8'h00, 8'h00, 8'h00, 8'h01,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [3:0] PC [5] = '{4'h2, 4'h3, 4'h9, 4'hA, 4'h1};
   localparam logic [13:0] PW [5] = '{14'h3FFF, 14'h0000, 14'h2AAA,
                                      14'h3F80, 14'h2000};
   localparam logic [3:0] TC [3] = '{4'h7, 4'h4, 4'hB};
   localparam logic [13:0] TA [3] = '{14'h3FFF, 14'h2AAA, 14'h2AAA};
   localparam logic [13:0] TB [3] = '{14'h0000, 14'h1555, 14'h1555};
   localparam logic [7:0] UM [4] = '{8'h08, 8'h48, 8'h88, 8'hC8};
   localparam logic [13:0] U2 [4] = '{14'h048D, 14'h048D, 14'h0000, 14'h048D};

   aotf_top dut (.CLK(clk), .SRST(srst), .SCLK(sclk), .CSB(csb),
      .SDIO_IN(sdio), .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe),
      .IN_VALID(in_valid), .IN_READY(in_ready), .IN_DATA(in_data),
      .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_DATA(out_data));
   aotf_host host (.clk(clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .sclk(sclk), .csb(csb), .sdio(sdio));

   // 125 MHz clock and a cycle ceiling well above the planned run
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         end_sim;
      end
   end

   // expected normal word: saturated trim, then coding, then complement
   function automatic logic [111:0] xw(logic [111:0] d);
      logic signed [16:0] t;
      logic [13:0] w;
      for (int i = 0; i < 8; i++) begin
         t = $signed({3'b000, d[i*14+:14]}) + $signed(trim_e[i]);
         w = (t < 0) ? 14'h0000 : (t > 17'sh3FFF) ? 14'h3FFF : t[13:0];
         w[13] = w[13] ^ tc_e;
         xw[i*14+:14] = inv_e[i] ? ~w : w;
      end
   endfunction

   task automatic chk_reg(string n, logic [7:0] ex, logic [7:0] g);
      checks_done++;
      if (g !== ex) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, ex, g);
      end
   endtask
   task automatic chk_word(string n, logic [111:0] ex, logic [111:0] g);
      checks_done++;
      if (g !== ex) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, ex, g);
      end
   endtask
   task automatic wr(logic [12:0] a, logic [7:0] d);
      logic [7:0] r;
      host.xfer(1'b0, a, d, r);
   endtask
   task automatic rd_chk(logic [12:0] a, logic [7:0] ex);
      logic [7:0] r;
      host.xfer(1'b1, a, 8'h00, r);
      chk_reg($sformatf("reg %h", a), ex, r);
   endtask
   // ready is judged at the falling edge, before the taking edge updates it
   task automatic push(logic [111:0] d);
      in_valid <= 1'b1;
      in_data <= d;
      do @(negedge clk); while (in_ready !== 1'b1);
      @(posedge clk);
      pushes++;
      in_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pop_chk(logic [111:0] ex);
      out_ready <= 1'b1;
      do @(negedge clk); while (out_valid !== 1'b1);
      chk_word("out_data", ex, out_data);
      @(posedge clk);
      out_ready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic end_sim;
      if (failures == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 11; i++) rd_chk(RA[i], RV[i]);
      // fill with the consumer stalled, then drain in order
      for (int i = 0; i < 16; i++) push(S + i);
      @(negedge clk);
      chk_reg("in_ready", 8'h00, {7'b0, in_ready});
      @(posedge clk);
      for (int i = 0; i < 16; i++) pop_chk(xw(S + i));
      wr(13'h0C, 8'hFF);
      rd_chk(13'h0C, 8'h04);
      wr(13'h15, 8'hFF);
      rd_chk(13'h15, 8'h31);
      wr(13'h14, 8'h00);
      tc_e = 1'b0;
      push(S);
      pop_chk(xw(S));
      wr(13'h05, 8'h01);
      wr(13'h10, 8'h7F);
      trim_e[0] = 8'h7F;
      trim_e[1] = 8'h7F;
      push(S);
      pop_chk(xw(S));
      wr(13'h10, 8'h80);
      trim_e[0] = 8'h80;
      trim_e[1] = 8'h80;
      push(S);
      pop_chk(xw(S));
      wr(13'h05, 8'h02);
      wr(13'h14, 8'h04);
      inv_e = 8'h0C;
      push(S);
      pop_chk(xw(S));
      wr(13'h05, 8'h3F);
      for (int i = 0; i < 5; i++) begin
         wr(13'h0D, {4'h0, PC[i]});
         push(S);
         pop_chk({8{PW[i]}});
      end
      // toggling patterns follow the count of accepted sample sets
      for (int i = 0; i < 6; i++) begin
         if (i % 2 == 0)
            wr(13'h0D, {4'h0, TC[i/2]});
         e = {8{pushes[0] ? TB[i/2] : TA[i/2]}};
         push(S);
         pop_chk(e);
      end
      wr(13'h19, 8'hCD);
      wr(13'h1A, 8'hAB);
      wr(13'h1B, 8'h34);
      wr(13'h1C, 8'h12);
      for (int i = 0; i < 4; i++) begin
         wr(13'h0D, UM[i]);
         push(S);
         push(S);
         pop_chk({8{14'h2AF3}});
         pop_chk({8{i == 0 ? 14'h2AF3 : U2[i]}});
      end
      // user mode bits must not disturb a fixed pattern
      wr(13'h0D, 8'hC2);
      push(S);
      pop_chk({8{14'h3FFF}});
      wr(13'h0D, 8'h00);
      push(S);
      pop_chk(xw(S));
      // pattern on channels 0 and 1 only, generator hold set via 2 and 3
      e = xw(S);
      e[27:0] = {2{14'h3FFF}};
      for (int k = 5; k < 7; k++) begin
         wr(13'h05, 8'h01);
         wr(13'h0D, k[7:0]);
         wr(13'h05, 8'h02);
         wr(13'h0D, 8'h30);
         push(S);
         push(S);
         pop_chk(e);
         pop_chk(e);
      end
      // holds released: seed first, then one step shifts a zero in
      wr(13'h05, 8'h3F);
      wr(13'h0D, 8'h06);
      push(S);
      push(S);
      pop_chk({8{14'h3FFF}});
      pop_chk({8{14'h3FDE}});
      // a second reset in mid-run must bring every register back
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 11; i++) rd_chk(RA[i], RV[i]);
      end_sim;
   end
endmodule
